// ---- inc/tmpr_pkg.sv ----
/*
 Constants, register offsets and reset values of the temperature monitor
 register file.
 Assumes a bus engine that hands over decoded byte commands on core_clk.
*/
package tmpr_pkg;
	// ****************************************
	// Read addresses
	// ****************************************
	localparam logic [7:0] RD_LOCAL_HIGH = 8'h00;
	localparam logic [7:0] RD_REMOTE_HIGH = 8'h01;
	localparam logic [7:0] RD_STATUS = 8'h02;
	localparam logic [7:0] RD_CONFIG_ONE = 8'h03;
	localparam logic [7:0] RD_RATE = 8'h04;
	localparam logic [7:0] RD_LOCAL_UP_HI = 8'h05;
	localparam logic [7:0] RD_LOCAL_LO_HI = 8'h06;
	localparam logic [7:0] RD_REMOTE_UP_HI = 8'h07;
	localparam logic [7:0] RD_REMOTE_LO_HI = 8'h08;
	localparam logic [7:0] RD_REMOTE_LOW = 8'h10;
	localparam logic [7:0] RD_LOCAL_LOW = 8'h15;
	localparam logic [7:0] RD_PART_ID = 8'hfd;
	localparam logic [7:0] RD_MAKER_ID = 8'hfe;
	// ****************************************
	// Write-only addresses and split write addresses
	// ****************************************
	localparam logic [7:0] WR_CONFIG_ONE = 8'h09;
	localparam logic [7:0] WR_RATE = 8'h0a;
	localparam logic [7:0] WR_LOCAL_UP_HI = 8'h0b;
	localparam logic [7:0] WR_LOCAL_LO_HI = 8'h0c;
	localparam logic [7:0] WR_REMOTE_UP_HI = 8'h0d;
	localparam logic [7:0] WR_REMOTE_LO_HI = 8'h0e;
	localparam logic [7:0] WR_ONE_SHOT = 8'h0f;
	localparam logic [7:0] WR_SOFT_RESET = 8'hfc;
	// ****************************************
	// Read/write at the same address
	// ****************************************
	localparam logic [7:0] RW_REMOTE_UP_LO = 8'h13;
	localparam logic [7:0] RW_REMOTE_LO_LO = 8'h14;
	localparam logic [7:0] RW_LOCAL_UP_LO = 8'h16;
	localparam logic [7:0] RW_LOCAL_LO_LO = 8'h17;
	localparam logic [7:0] RW_IDEALITY = 8'h18;
	localparam logic [7:0] RW_REMOTE_CRIT = 8'h19;
	localparam logic [7:0] RW_CONFIG_TWO = 8'h1a;
	localparam logic [7:0] RW_CHAN_DISABLE = 8'h1f;
	localparam logic [7:0] RW_LOCAL_CRIT = 8'h20;
	localparam logic [7:0] RW_HYSTERESIS = 8'h21;
	localparam logic [7:0] RW_FAULT_QUEUE = 8'h22;
	localparam logic [7:0] RW_BETA = 8'h25;
	// ****************************************
	// Reset values and field masks
	// ****************************************
	localparam logic [7:0] RST_SELECTOR = 8'h00;
	localparam logic [7:0] RST_STATUS = 8'h80;
	localparam logic [7:0] RST_CONFIG_ONE = 8'h00;
	localparam logic [7:0] RST_RATE = 8'h07;
	localparam logic [7:0] RST_UPPER_HI = 8'h55;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_CRIT_STD = 8'h55;
	localparam logic [7:0] RST_CRIT_HIGH = 8'h69;
	localparam logic [7:0] RST_CONFIG_TWO = 8'h1c;
	localparam logic [7:0] RST_HYSTERESIS = 8'h0a;
	localparam logic [7:0] RST_FAULT_QUEUE = 8'h70;
	localparam logic [7:0] RST_BETA = 8'h08;
	localparam logic [7:0] MASK_CONFIG_ONE = 8'he4;
	localparam logic [7:0] MASK_RATE = 8'h0f;
	localparam logic [7:0] MASK_LOW_NIBBLE = 8'hf0;
	localparam logic [7:0] MASK_CONFIG_TWO = 8'h1c;
	localparam logic [7:0] MASK_CHAN = 8'h03;
	localparam logic [7:0] MASK_FAULT_QUEUE = 8'h7e;
	localparam logic [7:0] MASK_BETA = 8'h0f;
	// Arbitrary identity values, not those of any real part
	localparam logic [7:0] PART_ID_VALUE = 8'ha5;
	localparam logic [7:0] MAKER_ID_VALUE = 8'h5a;
	// ****************************************
	// Link timing: core clock 20 MHz, two synchroniser stages
	// ****************************************
	localparam int CORE_CLK_MHZ = 20;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		TMPR_CH_NONE = 2'b00,
		TMPR_CH_LOCAL = 2'b01,
		TMPR_CH_REMOTE = 2'b11
	} tmpr_chan_t;
endpackage : tmpr_pkg

// ---- logic/tmpr_regfile.sv ----
/*
 Pointer-addressed register file of a local plus remote temperature
 monitor, single remote channel map.
 Assumes a two-wire protocol engine on core_clk that delivers one-cycle
 pulses: ptr_wr_stb with the selector byte, data_wr_stb with each data
 byte, rd_stb per byte read. Conversion results and comparator flags
 arrive from a measurement engine on the same clock.
*/
module tmpr_regfile
	import tmpr_pkg::*;
#(
	parameter bit HIGH_THRESHOLD = 1'b0
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Bus engine byte commands
	input wire logic ptr_wr_stb,
	input wire logic [7:0] ptr_wr_data,
	input wire logic data_wr_stb,
	input wire logic [7:0] data_wr_data,
	input wire logic rd_stb,
	input wire logic rd_first,
	output logic [7:0] rd_data,
	// Measurement engine
	input wire logic local_result_valid,
	input wire logic [11:0] local_result_bits,
	input wire logic remote_result_valid,
	input wire logic [11:0] remote_result_bits,
	input wire logic busy,
	input wire logic local_over_upper_flag,
	input wire logic local_under_lower_flag,
	input wire logic remote_over_upper_flag,
	input wire logic remote_under_lower_flag,
	input wire logic open_diode_flag,
	input wire logic remote_critical_flag,
	input wire logic local_critical_flag,
	// Control outputs
	output logic one_shot_req,
	output logic soft_reset_pulse,
	output logic [7:0] config_one,
	output logic [3:0] rate_code,
	output logic [7:0] config_two,
	output logic [1:0] channel_disable,
	output logic [7:0] ideality_correction,
	output logic [3:0] beta_code,
	output logic [7:0] local_critical_limit,
	output logic [7:0] remote_critical_limit,
	output logic [7:0] critical_hysteresis,
	output logic [2:0] therm_fault_count,
	output logic [2:0] alert_fault_count,
	output logic [15:0] local_upper_limit,
	output logic [15:0] local_lower_limit,
	output logic [15:0] remote_upper_limit,
	output logic [15:0] remote_lower_limit
);
	// ****************************************
	// Selector and local reset
	// ****************************************
	logic [7:0] selector;
	logic clear;
	logic wr_hit;
	logic [7:0] crit_reset;
	tmpr_chan_t last_high;
	logic [7:0] status_flags;

	assign crit_reset = HIGH_THRESHOLD ? RST_CRIT_HIGH : RST_CRIT_STD;
	// Software reset restores power-on state one cycle after the write
	assign clear = sys_rst | soft_reset_pulse;
	assign wr_hit = data_wr_stb;

	function automatic logic wr_at(input logic [7:0] sel, input logic [7:0] addr);
		wr_at = (sel == addr);
	endfunction : wr_at

	always_ff @(posedge core_clk)
	begin
		if (clear)
			selector <= RST_SELECTOR;
		else if (ptr_wr_stb)
			selector <= ptr_wr_data;
	end
	// Selector is not advanced by reads, so repeated reads stay put

	// ****************************************
	// Trigger writes
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			soft_reset_pulse <= 1'b0;
			one_shot_req <= 1'b0;
		end
		else
		begin
			soft_reset_pulse <= wr_hit && wr_at(selector, WR_SOFT_RESET);
			one_shot_req <= wr_hit && wr_at(selector, WR_ONE_SHOT) && !soft_reset_pulse;
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (clear)
		begin
			config_one <= RST_CONFIG_ONE;
			rate_code <= RST_RATE[3:0];
			config_two <= RST_CONFIG_TWO;
			channel_disable <= RST_ZERO[1:0];
			ideality_correction <= RST_ZERO;
			beta_code <= RST_BETA[3:0];
			critical_hysteresis <= RST_HYSTERESIS;
			{therm_fault_count, alert_fault_count} <= RST_FAULT_QUEUE[6:1];
		end
		else if (wr_hit)
		begin
			unique case (selector)
				WR_CONFIG_ONE: config_one <= data_wr_data & MASK_CONFIG_ONE;
				WR_RATE: rate_code <= data_wr_data[3:0];
				RW_CONFIG_TWO: config_two <= data_wr_data & MASK_CONFIG_TWO;
				RW_CHAN_DISABLE: channel_disable <= data_wr_data[1:0];
				RW_IDEALITY: ideality_correction <= data_wr_data;
				RW_BETA: beta_code <= data_wr_data[3:0];
				RW_HYSTERESIS: critical_hysteresis <= data_wr_data;
				RW_FAULT_QUEUE: {therm_fault_count, alert_fault_count} <= data_wr_data[6:1];
				default: ;
			endcase
		end
	end

	// ****************************************
	// Limit registers
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (clear)
		begin
			local_upper_limit <= {RST_UPPER_HI, RST_ZERO};
			local_lower_limit <= {RST_ZERO, RST_ZERO};
			remote_upper_limit <= {RST_UPPER_HI, RST_ZERO};
			remote_lower_limit <= {RST_ZERO, RST_ZERO};
			local_critical_limit <= crit_reset;
			remote_critical_limit <= crit_reset;
		end
		else if (wr_hit)
		begin
			// Separate write addresses for the high bytes
			unique case (selector)
				WR_LOCAL_UP_HI: local_upper_limit[15:8] <= data_wr_data;
				WR_LOCAL_LO_HI: local_lower_limit[15:8] <= data_wr_data;
				WR_REMOTE_UP_HI: remote_upper_limit[15:8] <= data_wr_data;
				WR_REMOTE_LO_HI: remote_lower_limit[15:8] <= data_wr_data;
				RW_LOCAL_UP_LO: local_upper_limit[7:0] <= data_wr_data & MASK_LOW_NIBBLE;
				RW_LOCAL_LO_LO: local_lower_limit[7:0] <= data_wr_data & MASK_LOW_NIBBLE;
				RW_REMOTE_UP_LO: remote_upper_limit[7:0] <= data_wr_data & MASK_LOW_NIBBLE;
				RW_REMOTE_LO_LO: remote_lower_limit[7:0] <= data_wr_data & MASK_LOW_NIBBLE;
				RW_LOCAL_CRIT: local_critical_limit <= data_wr_data;
				RW_REMOTE_CRIT: remote_critical_limit <= data_wr_data;
				default: ;
			endcase
		end
	end

	// ****************************************
	// Status and result coherence
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (clear)
			status_flags <= RST_STATUS;
		else
			status_flags <= {busy, local_over_upper_flag, local_under_lower_flag,
				remote_over_upper_flag, remote_under_lower_flag, open_diode_flag,
				remote_critical_flag, local_critical_flag};
	end

	logic take_local;
	logic take_remote;
	logic lapse_local;
	logic lapse_remote;
	logic [7:0] local_hi;
	logic [7:0] local_lo;
	logic [7:0] remote_hi;
	logic [7:0] remote_lo;

	// A high byte read captures; any later read other than that channel's low byte or a continued read drops the guarantee
	assign take_local = rd_stb && rd_first && selector == RD_LOCAL_HIGH;
	assign take_remote = rd_stb && rd_first && selector == RD_REMOTE_HIGH;
	assign lapse_local = rd_stb && !take_local &&
		!(last_high == TMPR_CH_LOCAL && (selector == RD_LOCAL_LOW || !rd_first));
	assign lapse_remote = rd_stb && !take_remote &&
		!(last_high == TMPR_CH_REMOTE && (selector == RD_REMOTE_LOW || !rd_first));

	always_ff @(posedge core_clk)
	begin
		if (clear)
			last_high <= TMPR_CH_NONE;
		else if (take_local)
			last_high <= TMPR_CH_LOCAL;
		else if (take_remote)
			last_high <= TMPR_CH_REMOTE;
		else if (rd_stb && rd_first)
			last_high <= TMPR_CH_NONE;
	end

	tmpr_snapshot local_snap (
		.core_clk(core_clk),
		.clear(clear),
		.result_valid(local_result_valid),
		.result_bits(local_result_bits),
		.take_high(take_local),
		.lapse(lapse_local),
		.high_byte(local_hi),
		.low_byte(local_lo)
	);

	tmpr_snapshot remote_snap (
		.core_clk(core_clk),
		.clear(clear),
		.result_valid(remote_result_valid),
		.result_bits(remote_result_bits),
		.take_high(take_remote),
		.lapse(lapse_remote),
		.high_byte(remote_hi),
		.low_byte(remote_lo)
	);

	// ****************************************
	// Read data
	// ****************************************
	logic [7:0] next_rd_data;

	always_comb
	begin
		next_rd_data = 8'h00;
		if (!rd_first && last_high == TMPR_CH_LOCAL)
			next_rd_data = local_lo;
		else if (!rd_first && last_high == TMPR_CH_REMOTE)
			next_rd_data = remote_lo;
		else
		begin
			unique case (selector)
				RD_LOCAL_HIGH: next_rd_data = local_hi;
				RD_LOCAL_LOW: next_rd_data = local_lo;
				RD_REMOTE_HIGH: next_rd_data = remote_hi;
				RD_REMOTE_LOW: next_rd_data = remote_lo;
				RD_STATUS: next_rd_data = status_flags;
				RD_CONFIG_ONE: next_rd_data = config_one;
				RD_RATE: next_rd_data = {4'h0, rate_code};
				RD_LOCAL_UP_HI: next_rd_data = local_upper_limit[15:8];
				RD_LOCAL_LO_HI: next_rd_data = local_lower_limit[15:8];
				RD_REMOTE_UP_HI: next_rd_data = remote_upper_limit[15:8];
				RD_REMOTE_LO_HI: next_rd_data = remote_lower_limit[15:8];
				RW_LOCAL_UP_LO: next_rd_data = local_upper_limit[7:0];
				RW_LOCAL_LO_LO: next_rd_data = local_lower_limit[7:0];
				RW_REMOTE_UP_LO: next_rd_data = remote_upper_limit[7:0];
				RW_REMOTE_LO_LO: next_rd_data = remote_lower_limit[7:0];
				RW_IDEALITY: next_rd_data = ideality_correction;
				RW_REMOTE_CRIT: next_rd_data = remote_critical_limit;
				RW_CONFIG_TWO: next_rd_data = config_two;
				RW_CHAN_DISABLE: next_rd_data = {6'h00, channel_disable};
				RW_LOCAL_CRIT: next_rd_data = local_critical_limit;
				RW_HYSTERESIS: next_rd_data = critical_hysteresis;
				RW_FAULT_QUEUE: next_rd_data = {1'b0, therm_fault_count, alert_fault_count, 1'b0};
				RW_BETA: next_rd_data = {4'h0, beta_code};
				RD_PART_ID: next_rd_data = PART_ID_VALUE;
				RD_MAKER_ID: next_rd_data = MAKER_ID_VALUE;
				// Write-only and unmapped addresses read zero
				default: next_rd_data = 8'h00;
			endcase
		end
	end

	// Data is registered on the read strobe, held until the next one
	always_ff @(posedge core_clk)
	begin
		if (clear)
			rd_data <= 8'h00;
		else if (rd_stb)
			rd_data <= next_rd_data;
	end
endmodule : tmpr_regfile

// ---- logic/tmpr_snapshot.sv ----
/*
 Result snapshot for one channel: holds the low nibble of the conversion
 whose high byte was last read, so a following low byte read is coherent.
 Assumes result updates and read strobes on the same clock.
*/
module tmpr_snapshot
	import tmpr_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic clear,
	// Conversion result
	input wire logic result_valid,
	input wire logic [11:0] result_bits,
	// Read control
	input wire logic take_high,
	input wire logic lapse,
	// Bytes
	output logic [7:0] high_byte,
	output logic [7:0] low_byte
);
	logic [11:0] live;
	logic [3:0] held;
	logic held_valid;

	// Live result, zero until the first measurement
	always_ff @(posedge core_clk)
	begin
		if (clear)
			live <= 12'h000;
		else if (result_valid)
			live <= result_bits;
	end

	// Capture the low nibble together with the high byte
	always_ff @(posedge core_clk)
	begin
		if (clear)
		begin
			held <= 4'h0;
			held_valid <= 1'b0;
		end
		else if (take_high)
		begin
			held <= live[3:0];
			held_valid <= 1'b1;
		end
		else if (lapse)
			held_valid <= 1'b0;
	end

	assign high_byte = live[11:4];
	// Without a fresh capture the low byte shows the live value
	assign low_byte = {(held_valid ? held : live[3:0]), 4'h0};
endmodule : tmpr_snapshot

// ---- sim/test_tmpr_regfile.sv ----
/*
 Self-checking bench for the temperature monitor register file.
 Assumes the host model drives the bus and the bench plays the
 measurement engine.
*/
module test_tmpr_regfile
	import tmpr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ptr_wr_stb, data_wr_stb, rd_stb, rd_first, l_vld = 1'b0, r_vld = 1'b0;
	logic [7:0] ptr_wr_data, data_wr_data, rd_data, config_one, config_two, v;
	logic [11:0] l_bits = 12'h000, r_bits = 12'h000;
	logic [7:0] stat_in = 8'h80;
	logic one_shot_req, soft_reset_pulse;
	logic [3:0] rate_code;
	logic [1:0] channel_disable;
	logic [2:0] therm_fault_count, alert_fault_count;
	logic [15:0] local_upper_limit, local_lower_limit, remote_upper_limit, remote_lower_limit;
	logic [7:0] ideality_correction, local_critical_limit, remote_critical_limit;
	logic [7:0] critical_hysteresis;
	logic [3:0] beta_code;
	int err_count = 0;
	int n_compared = 0;
	int cycles = 0;
	// ****************************************
	// Tables: {address, value} and {write, read, data, value}
	// ****************************************
	localparam logic [15:0] DEF_TAB [28] = '{
		16'h0000, 16'h0100, 16'h1000, 16'h1500,
		16'h0280,
		16'h0300,
		16'h0407,
		16'h1a1c,
		16'h1f00,
		16'h2270,
		{8'h19, RST_CRIT_HIGH}, {8'h20, RST_CRIT_HIGH},
		16'h0f00, 16'hfc00, 16'h3000,
		16'h0555, 16'h0600, 16'h0755, 16'h0800, 16'h1300, 16'h1400, 16'h1600, 16'h1700,
		16'h1800, 16'h210a, 16'h2508, {8'hfd, PART_ID_VALUE}, {8'hfe, MAKER_ID_VALUE}};
	localparam logic [31:0] WR_TAB [18] = '{
		32'h0903ffe4,
		32'h0a04ff0f,
		32'h1a1ae300,
		32'h1f1fff03,
		32'h2222ff7e,
		32'h0b05ffff, 32'h0c06ffff, 32'h0d07ffff, 32'h0e08ffff, 32'h1313fff0, 32'h1414fff0,
		32'h1616fff0, 32'h1717fff0, 32'h1818ffff, 32'h1919ffff, 32'h2020ffff, 32'h2121ffff,
		32'h2525ff0f};
	always #25 core_clk = ~core_clk;
	tmpr_host_model HOST (.core_clk(core_clk), .ptr_wr_stb(ptr_wr_stb),
		.ptr_wr_data(ptr_wr_data), .data_wr_stb(data_wr_stb), .data_wr_data(data_wr_data),
		.rd_stb(rd_stb), .rd_first(rd_first), .rd_data(rd_data));
	tmpr_regfile #(.HIGH_THRESHOLD(1'b1)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
		.ptr_wr_stb(ptr_wr_stb), .ptr_wr_data(ptr_wr_data), .data_wr_stb(data_wr_stb),
		.data_wr_data(data_wr_data), .rd_stb(rd_stb), .rd_first(rd_first), .rd_data(rd_data),
		.local_result_valid(l_vld), .local_result_bits(l_bits), .remote_result_valid(r_vld),
		.remote_result_bits(r_bits), .busy(stat_in[7]), .local_over_upper_flag(stat_in[6]),
		.local_under_lower_flag(stat_in[5]), .remote_over_upper_flag(stat_in[4]),
		.remote_under_lower_flag(stat_in[3]), .open_diode_flag(stat_in[2]),
		.remote_critical_flag(stat_in[1]), .local_critical_flag(stat_in[0]),
		.one_shot_req(one_shot_req), .soft_reset_pulse(soft_reset_pulse),
		.config_one(config_one), .rate_code(rate_code), .config_two(config_two),
		.channel_disable(channel_disable), .ideality_correction(ideality_correction),
		.beta_code(beta_code), .local_critical_limit(local_critical_limit),
		.remote_critical_limit(remote_critical_limit),
		.critical_hysteresis(critical_hysteresis),
		.therm_fault_count(therm_fault_count), .alert_fault_count(alert_fault_count),
		.local_upper_limit(local_upper_limit), .local_lower_limit(local_lower_limit),
		.remote_upper_limit(remote_upper_limit), .remote_lower_limit(remote_lower_limit));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			err_count++;
		end
	endtask : chk
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		HOST.point(a);
		HOST.read(1'b1, v);
		chk(v, e);
	endtask : rd
	task automatic put(input logic rem, input logic [11:0] val);
		@(posedge core_clk);
		#1;
		{r_vld, l_vld} = rem ? 2'b10 : 2'b01;
		{r_bits, l_bits} = rem ? {val, l_bits} : {r_bits, val};
		@(posedge core_clk);
		#1;
		{r_vld, l_vld} = 2'b00;
	endtask : put
	task automatic tally_and_finish();
		if (err_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_pointer_reset();
		put(1'b0, 12'h9e1);
		HOST.read(1'b1, v);
		chk(v, 8'h9e);
		// Second reset in mid-run
		sys_rst = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		sys_rst = 1'b0;
	endtask : t_pointer_reset
	task automatic t_defaults();
		foreach (DEF_TAB[i])
			rd(DEF_TAB[i][15:8], DEF_TAB[i][7:0]);
	endtask : t_defaults
	task automatic t_write_map();
		HOST.write(8'h00, 8'hff);
		rd(8'h00, 8'h00);
		foreach (WR_TAB[i])
		begin
			HOST.write(WR_TAB[i][31:24], WR_TAB[i][15:8]);
			rd(WR_TAB[i][23:16], WR_TAB[i][7:0]);
		end
		HOST.write(8'h03, 8'h00);
		rd(8'h03, 8'he4);
		chk(config_one, 8'he4);
		chk(rate_code, 4'hf);
		chk(config_two, 8'h00);
		chk(channel_disable, 2'h3);
		chk({therm_fault_count, alert_fault_count}, 6'h3f);
		chk(local_upper_limit, 16'hfff0);
		chk(local_lower_limit, 16'hfff0);
		chk(remote_upper_limit, 16'hfff0);
		chk(remote_lower_limit, 16'hfff0);
		chk({local_critical_limit, remote_critical_limit}, 16'hffff);
		chk({ideality_correction, critical_hysteresis}, 16'hffff);
		chk(beta_code, 4'hf);
	endtask : t_write_map
	task automatic t_status();
		foreach (DEF_TAB[i])
		begin
			stat_in = 8'h55 << i[0];
			rd(8'h02, stat_in);
			if (i == 3)
				break;
		end
		stat_in = 8'h80;
	endtask : t_status
	task automatic t_coherent();
		put(1'b0, 12'habc);
		rd(8'h00, 8'hab);
		put(1'b0, 12'h123);
		HOST.read(1'b0, v);
		chk(v, 8'hc0);
		put(1'b1, 12'h5a7);
		rd(8'h01, 8'h5a);
		put(1'b1, 12'h0f1);
		rd(8'h10, 8'h70);
		rd(8'h01, 8'h0f);
		HOST.read(1'b1, v);
		chk(v, 8'h0f);
		rd(8'h02, 8'h80);
		// Fresh conversion after the lapse must show through
		put(1'b1, 12'h0f6);
		rd(8'h10, 8'h60);
		rd(8'h15, 8'h30);
	endtask : t_coherent
	task automatic t_soft();
		HOST.write(8'h0f, 8'h77);
		chk(one_shot_req, 1'b1);
		rd(8'h0f, 8'h00);
		HOST.write(8'hfc, 8'h3c);
		chk(soft_reset_pulse, 1'b1);
		t_defaults();
		chk({local_critical_limit, remote_critical_limit}, {RST_CRIT_HIGH, RST_CRIT_HIGH});
		chk(rate_code, RST_RATE[3:0]);
		chk(beta_code, RST_BETA[3:0]);
	endtask : t_soft
	// ****************************************
	// Main sequence and hang guard
	// ****************************************
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			err_count++;
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (6) @(posedge core_clk);
		#1;
		sys_rst = 1'b0;
		t_pointer_reset();
		t_defaults();
		t_write_map();
		t_status();
		t_coherent();
		t_soft();
		tally_and_finish();
	end
endmodule : test_tmpr_regfile

// ---- sim/tmpr_host_model.sv ----
/*
 Host model: issues selector writes, data writes and byte reads as
 one-cycle strobes, changed just after the clock edge.
 Assumes it is the only driver of the register file's bus inputs.
*/
module tmpr_host_model
	import tmpr_pkg::*;
(
	// Clock
	input wire logic core_clk,
	// Byte commands
	output logic ptr_wr_stb,
	output logic [7:0] ptr_wr_data,
	output logic data_wr_stb,
	output logic [7:0] data_wr_data,
	output logic rd_stb,
	output logic rd_first,
	// Read return
	input wire logic [7:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		ptr_wr_stb = 1'b0;
		ptr_wr_data = 8'h00;
		data_wr_stb = 1'b0;
		data_wr_data = 8'h00;
		rd_stb = 1'b0;
		rd_first = 1'b0;
	end
	// Selector byte alone just repoints
	task automatic point(input logic [7:0] sel);
		@(posedge core_clk);
		#1;
		ptr_wr_stb = 1'b1;
		ptr_wr_data = sel;
		@(posedge core_clk);
		#1;
		ptr_wr_stb = 1'b0;
		// Released lines must not keep the last byte
		ptr_wr_data = ~sel;
	endtask : point
	task automatic write(input logic [7:0] sel, input logic [7:0] val);
		point(sel);
		data_wr_stb = 1'b1;
		data_wr_data = val;
		@(posedge core_clk);
		#1;
		data_wr_stb = 1'b0;
		data_wr_data = ~val;
	endtask : write
	task automatic read(input logic first, output logic [7:0] val);
		@(posedge core_clk);
		#1;
		rd_stb = 1'b1;
		rd_first = first;
		@(posedge core_clk);
		#1;
		val = rd_data;
		rd_stb = 1'b0;
		rd_first = ~first;
	endtask : read
endmodule : tmpr_host_model

// ---- sim/tmpr_regfile_sva.sv ----
/*
 Checker for the temperature monitor register file, bus-side relations.
 Assumes it is bound into tmpr_regfile and sees only its ports.
*/
module tmpr_regfile_sva
	import tmpr_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Bus commands
	input wire logic ptr_wr_stb,
	input wire logic [7:0] ptr_wr_data,
	input wire logic data_wr_stb,
	input wire logic [7:0] data_wr_data,
	input wire logic rd_stb,
	input wire logic rd_first,
	input wire logic [7:0] rd_data,
	// Controls
	input wire logic one_shot_req,
	input wire logic soft_reset_pulse,
	input wire logic [7:0] config_one,
	input wire logic [3:0] rate_code,
	input wire logic [7:0] config_two
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sel_q;
	logic hit_one;
	logic hit_soft;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	// ****************************************
	// Selector shadow
	// ****************************************
	// Soft reset clears it on the edge that ends the pulse
	always_ff @(posedge core_clk)
	begin
		if (sys_rst || soft_reset_pulse)
			sel_q <= 8'h00;
		else if (ptr_wr_stb)
			sel_q <= ptr_wr_data;
	end
	assign hit_one = data_wr_stb && (sel_q == WR_ONE_SHOT);
	assign hit_soft = data_wr_stb && (sel_q == WR_SOFT_RESET);
	// ****************************************
	// Assertions
	// ****************************************
	chk_oneshot_cause: assert property (hit_one |=> one_shot_req)
		else $error("one-shot request missing after trigger write");
	chk_oneshot_only: assert property (one_shot_req |-> $past(hit_one))
		else $error("one-shot request without trigger write");
	chk_soft_cause: assert property (hit_soft |=> soft_reset_pulse)
		else $error("soft reset pulse missing");
	chk_soft_restore: assert property (soft_reset_pulse |=>
		(config_one == RST_CONFIG_ONE) && (rate_code == RST_RATE[3:0]) &&
		(config_two == RST_CONFIG_TWO))
		else $error("soft reset did not restore controls");
	chk_low_nibble: assert property ((rd_stb &&
		(sel_q == RD_REMOTE_LOW || sel_q == RD_LOCAL_LOW)) |=> (rd_data[3:0] == 4'h0))
		else $error("low byte lower nibble not zero");
	chk_rate_write: assert property ((data_wr_stb && sel_q == WR_RATE) |=>
		({4'h0, rate_code} == ($past(data_wr_data) & MASK_RATE)))
		else $error("rate code not taken from write");
	chk_cfg_write: assert property ((data_wr_stb && sel_q == WR_CONFIG_ONE) |=>
		(config_one == ($past(data_wr_data) & MASK_CONFIG_ONE)))
		else $error("config one not taken from write");
	chk_cfg_readonly: assert property ((data_wr_stb && sel_q == RD_CONFIG_ONE) |=>
		$stable(config_one))
		else $error("config one changed by write to read address");
	chk_maker_read: assert property ((rd_stb && rd_first && sel_q == RD_MAKER_ID) |=>
		(rd_data == MAKER_ID_VALUE))
		else $error("selector did not pick identity register");
endmodule : tmpr_regfile_sva

bind tmpr_regfile tmpr_regfile_sva chk (
	.core_clk(core_clk), .sys_rst(sys_rst), .ptr_wr_stb(ptr_wr_stb),
	.ptr_wr_data(ptr_wr_data), .data_wr_stb(data_wr_stb), .data_wr_data(data_wr_data),
	.rd_stb(rd_stb), .rd_first(rd_first), .rd_data(rd_data), .one_shot_req(one_shot_req),
	.soft_reset_pulse(soft_reset_pulse), .config_one(config_one), .rate_code(rate_code),
	.config_two(config_two)
);
